// File: logic/uart_bus_decode_defines.svh
// Function
// - strap high selects separate-strobe bus style
// - strap low selects single-strobe bus style
// - single-strobe: write pin becomes read/write direction
// - reset pin active low single-strobe, high otherwise
// - single-strobe ignores the read strobe pin
// - single-strobe: channel interrupts wired-OR, open source
// - three-bit index picks the channel register
// - channel bits pick channel while common select low
// - common select low enables all four channels
// - separate-strobe: channel bits become second, third selects
// - separate-strobe: own low select picks one channel
// - falling read strobe drives indexed register out
// - falling write strobe loads bus into indexed register
`ifndef UART_BUS_DECODE_DEFINES_SVH
`define UART_BUS_DECODE_DEFINES_SVH

`define CHAN_COUNT      4
`define INDEX_WIDTH     3
`define DATA_WIDTH      8
`define PIN_WIDTH       19

// packed pin vector positions
`define PIN_DATA_LSB    0
`define PIN_IDX_LSB     8
`define PIN_RD_N        11
`define PIN_WR_N        12
`define PIN_CS_A_N      13
`define PIN_CSEL_LSB    14
`define PIN_CS_D_N      16
`define PIN_RESET       17
`define PIN_STYLE       18

// synchroniser reset value: strobes and selects idle high, separate style
`define PIN_IDLE        19'h5f800

`define STYLE_SEPARATE  1'b1
`define STYLE_SINGLE    1'b0

`endif

// File: logic/uart_bus_decode_pkg.sv
package uart_bus_decode_pkg;

    typedef enum logic {
        SINGLE_STROBE,
        SEPARATE_STROBE
    } bus_style_type;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ_FETCH,
        ACC_READ_DRIVE,
        ACC_WRITE_HOLD
    } access_state_type;

    typedef logic [3:0] chan_sel_type;

endpackage

// File: logic/pin_sync_if.sv
`timescale 1ns/100ps
interface pin_sync_if;
    logic       style;
    logic       reset_pin;
    logic       cs_d_n;
    logic [1:0] csel;
    logic       cs_a_n;
    logic       wr_n;
    logic       rd_n;
    logic [2:0] idx;
    logic [7:0] data;

    modport src (
        output style, reset_pin, cs_d_n, csel, cs_a_n, wr_n, rd_n, idx, data
    );
    modport dst (
        input  style, reset_pin, cs_d_n, csel, cs_a_n, wr_n, rd_n, idx, data
    );
endinterface

// File: logic/pin_sync.sv
`timescale 1ns/100ps
`include "uart_bus_decode_defines.svh"
module pin_sync (
    // clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    // raw pins
    input  wire logic [`PIN_WIDTH-1:0]   pins_i,
    // synchronised pins
    pin_sync_if.src                      link
);
    logic [`PIN_WIDTH-1:0] stage1;
    logic [`PIN_WIDTH-1:0] stage2;

    // stage1 feeds stage2 only; everything downstream reads stage2
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stage1 <= `PIN_IDLE;
            stage2 <= `PIN_IDLE;
        end else begin
            stage1 <= pins_i;
            stage2 <= stage1;
        end
    end

    assign link.data      = stage2[`PIN_DATA_LSB +: 8];
    assign link.idx       = stage2[`PIN_IDX_LSB +: 3];
    assign link.rd_n      = stage2[`PIN_RD_N];
    assign link.wr_n      = stage2[`PIN_WR_N];
    assign link.cs_a_n    = stage2[`PIN_CS_A_N];
    assign link.csel      = stage2[`PIN_CSEL_LSB +: 2];
    assign link.cs_d_n    = stage2[`PIN_CS_D_N];
    assign link.reset_pin = stage2[`PIN_RESET];
    assign link.style     = stage2[`PIN_STYLE];
endmodule // pin_sync

// File: logic/quad_uart_host_bus_decode.sv
`timescale 1ns/100ps
`include "uart_bus_decode_defines.svh"
module quad_uart_host_bus_decode (
    // clock and reset
    input  wire logic                                ref_clk_i,
    input  wire logic                                rst_n_i,
    // host bus pins
    input  wire logic                                bus_style_i,
    input  wire logic                                reset_pin_i,
    input  wire logic                                cs_a_n_i,
    input  wire logic [1:0]                          channel_select_bits_i,
    input  wire logic                                cs_d_n_i,
    input  wire logic [2:0]                          register_index_i,
    input  wire logic                                read_strobe_n_i,
    input  wire logic                                write_strobe_n_i,
    input  wire logic [7:0]                          data_i,
    output logic      [7:0]                          data_o,
    output logic                                     data_oe_o,
    // interrupt pins
    output logic      [3:0]                          chan_irq_o,
    output logic      [3:0]                          chan_irq_oe_o,
    output logic                                     irq_o,
    output logic                                     irq_oe_o,
    // uart channel side
    output uart_bus_decode_pkg::chan_sel_type        core_sel_o,
    output logic      [2:0]                          core_index_o,
    output logic      [7:0]                          core_wdata_o,
    output logic                                     core_wr_o,
    output logic                                     core_rd_o,
    input  wire logic [7:0]                          core_rdata_i,
    input  wire logic [3:0]                          core_int_i,
    output logic                                     core_reset_o,
    output uart_bus_decode_pkg::bus_style_type       style_o
);
    import uart_bus_decode_pkg::*;

    pin_sync_if link ();

    pin_sync u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pins_i    ({bus_style_i, reset_pin_i, cs_d_n_i, channel_select_bits_i,
                     cs_a_n_i, write_strobe_n_i, read_strobe_n_i,
                     register_index_i, data_i}),
        .link      (link)
    );

    // one-hot check, used for the separate style only
    function automatic logic is_onehot(input logic [3:0] v);
        return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
    endfunction

    function automatic chan_sel_type chan_decode(input logic [1:0] n);
        return chan_sel_type'(4'h1 << n);
    endfunction

    access_state_type state;
    access_state_type next_state;
    logic             access_prev;

    wire        sep        = (link.style == `STYLE_SEPARATE);
    // separate style: csel bits are the second and third channel selects
    wire  [3:0] sel_sep    = {~link.cs_d_n, ~link.csel[1], ~link.csel[0],
                              ~link.cs_a_n};
    // two selects low at once is a host fault; treated as no selection
    wire  [3:0] sel_sep_ok = is_onehot(sel_sep) ? sel_sep : 4'h0;
    wire  [3:0] sel_single = link.cs_a_n ? 4'h0 : chan_decode(link.csel);
    wire  [3:0] sel_now    = sep ? sel_sep_ok : sel_single;
    wire        any_sel    = (sel_now != 4'h0);

    // single style: the common select is the data strobe, direction from wr pin
    wire        access_now = sep ? (~link.rd_n | ~link.wr_n) : ~link.cs_a_n;
    wire        access_new = access_now & ~access_prev;
    wire        dir_read   = sep ? (~link.rd_n & link.wr_n) : link.wr_n;
    wire        dir_write  = sep ? (~link.wr_n & link.rd_n) : ~link.wr_n;
    wire        read_ev    = access_new & any_sel & dir_read;
    wire        write_ev   = access_new & any_sel & dir_write;
    wire        hold       = access_now & any_sel;

    wire        any_int    = |core_int_i;
    wire        next_reset = sep ? link.reset_pin : ~link.reset_pin;

    always_comb begin
        next_state = state;
        case (state)
            ACC_IDLE: begin
                if (read_ev) begin
                    next_state = ACC_READ_FETCH;
                end else if (write_ev) begin
                    next_state = ACC_WRITE_HOLD;
                end
            end
            ACC_READ_FETCH: begin
                next_state = hold ? ACC_READ_DRIVE : ACC_IDLE;
            end
            ACC_READ_DRIVE: begin
                next_state = hold ? ACC_READ_DRIVE : ACC_IDLE;
            end
            ACC_WRITE_HOLD: begin
                next_state = hold ? ACC_WRITE_HOLD : ACC_IDLE;
            end
            default: begin
                next_state = ACC_IDLE;
            end
        endcase
    end

    wire start_read  = (state == ACC_IDLE) && read_ev;
    wire start_write = (state == ACC_IDLE) && write_ev;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state       <= ACC_IDLE;
            access_prev <= 1'b0;
        end else begin
            state       <= next_state;
            access_prev <= access_now;
        end
    end

    // access address and strobes toward the channels
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            core_sel_o   <= 4'h0;
            core_index_o <= 3'h0;
            core_wdata_o <= 8'h00;
            core_wr_o    <= 1'b0;
            core_rd_o    <= 1'b0;
        end else begin
            core_wr_o <= start_write;
            core_rd_o <= start_read;
            if (start_read || start_write) begin
                core_sel_o   <= sel_now;
                core_index_o <= link.idx;
            end
            if (start_write) begin
                core_wdata_o <= link.data;
            end
        end
    end

    // read data is taken one cycle after the fetch strobe and held
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= (next_state == ACC_READ_DRIVE);
            if (state == ACC_READ_FETCH) begin
                data_o <= core_rdata_i;
            end
        end
    end

    // interrupt pins follow the style; open source drives only the high level
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            chan_irq_o    <= 4'h0;
            chan_irq_oe_o <= 4'h0;
            irq_o         <= 1'b0;
            irq_oe_o      <= 1'b0;
            core_reset_o  <= 1'b1;
            style_o       <= SEPARATE_STROBE;
        end else begin
            chan_irq_o    <= sep ? core_int_i : 4'h0;
            chan_irq_oe_o <= sep ? 4'hf : 4'h0;
            irq_o         <= ~sep & any_int;
            irq_oe_o      <= ~sep & any_int;
            core_reset_o  <= next_reset;
            style_o       <= sep ? SEPARATE_STROBE : SINGLE_STROBE;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_read_start;
        start_read;
    endsequence

    sequence s_fetch_then_drive;
        core_rd_o && hold ##1 hold;
    endsequence

    sequence s_sep_steady;
        sep ##1 sep;
    endsequence

    property p_read_strobe;
        s_read_start |=> core_rd_o && core_sel_o == $past(sel_now);
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read event did not raise core read strobe");

    property p_read_drive;
        s_fetch_then_drive |=> data_oe_o && data_o == $past(core_rdata_i, 2);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read data not driven after fetch");

    property p_write_load;
        start_write |=> core_wr_o && core_wdata_o == $past(link.data)
                        && core_index_o == $past(link.idx);
    endproperty
    a_write_load: assert property (p_write_load)
        else $error("write event did not load data and index");

    property p_no_sel_no_strobe;
        !any_sel |=> !core_wr_o && !core_rd_o && !data_oe_o;
    endproperty
    a_no_sel_no_strobe: assert property (p_no_sel_no_strobe)
        else $error("strobe or drive without a selected channel");

    property p_reset_polarity;
        1'b1 |=> core_reset_o == ($past(sep) ? $past(link.reset_pin)
                                             : !$past(link.reset_pin));
    endproperty
    a_reset_polarity: assert property (p_reset_polarity)
        else $error("channel reset polarity wrong for bus style");

    property p_wired_or;
        !sep ##1 !sep |-> irq_oe_o == $past(any_int) && chan_irq_oe_o == 4'h0;
    endproperty
    a_wired_or: assert property (p_wired_or)
        else $error("shared interrupt does not follow channel interrupts");

    property p_single_select;
        !sep && start_write |=> core_sel_o == chan_decode($past(link.csel));
    endproperty
    a_single_select: assert property (p_single_select)
        else $error("single style channel decode wrong");

    property p_single_ignores_rd;
        !sep && access_new && any_sel && link.wr_n && state == ACC_IDLE
            |=> core_rd_o;
    endproperty
    a_single_ignores_rd: assert property (p_single_ignores_rd)
        else $error("single style read depends on read strobe pin");

    property p_sep_select;
        sep && (start_write || start_read) |=> core_sel_o == $past(sel_sep);
    endproperty
    a_sep_select: assert property (p_sep_select)
        else $error("separate style channel select wrong");

    property p_idle_release;
        state == ACC_IDLE && !read_ev |=> !data_oe_o;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data bus driven outside a read");

    property p_sep_irq_pins;
        s_sep_steady |-> chan_irq_o == $past(core_int_i) && chan_irq_oe_o == 4'hf
                         && !irq_oe_o;
    endproperty
    a_sep_irq_pins: assert property (p_sep_irq_pins)
        else $error("separate style channel interrupt pins wrong");

    property p_wr_single_cycle;
        core_wr_o |=> !core_wr_o;
    endproperty
    a_wr_single_cycle: assert property (p_wr_single_cycle)
        else $error("core write strobe longer than one cycle");

    property p_rd_single_cycle;
        core_rd_o |=> !core_rd_o;
    endproperty
    a_rd_single_cycle: assert property (p_rd_single_cycle)
        else $error("core read strobe longer than one cycle");

    property p_both_strobes_refused;
        sep && !link.rd_n && !link.wr_n |=> !core_wr_o && !core_rd_o;
    endproperty
    a_both_strobes_refused: assert property (p_both_strobes_refused)
        else $error("access taken with both strobes low");

    property p_multi_select_refused;
        sep && !is_onehot(sel_sep) |=> !core_wr_o && !core_rd_o;
    endproperty
    a_multi_select_refused: assert property (p_multi_select_refused)
        else $error("access taken without exactly one channel select");

    property p_drive_release;
        data_oe_o && !hold |=> !data_oe_o;
    endproperty
    a_drive_release: assert property (p_drive_release)
        else $error("data bus still driven after strobe release");

    property p_style_out;
        1'b1 |=> style_o == ($past(sep) ? SEPARATE_STROBE : SINGLE_STROBE);
    endproperty
    a_style_out: assert property (p_style_out)
        else $error("style output does not follow the strap");

    property p_read_index;
        start_read |=> core_index_o == $past(link.idx);
    endproperty
    a_read_index: assert property (p_read_index)
        else $error("read did not capture the register index");

    property p_single_dir_write;
        !sep && access_new && state == ACC_IDLE && !link.wr_n |=> core_wr_o && !core_rd_o;
    endproperty
    a_single_dir_write: assert property (p_single_dir_write)
        else $error("single style direction low did not give a write");

endmodule // quad_uart_host_bus_decode

// File: bench/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
    // clock
    input  wire logic       ref_clk_i,
    // device side of the data wire
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_i,
    // host pins
    output logic            cs_a_n_o,
    output logic [1:0]      csel_o,
    output logic            cs_d_n_o,
    output logic [2:0]      idx_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic [7:0]      data_o
);
    logic       drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last = 8'h00;
    initial cs_a_n_o = 1'b1;
    initial csel_o = 2'b11;
    initial cs_d_n_o = 1'b1;
    initial idx_o = 3'h0;
    initial rd_n_o = 1'b1;
    initial wr_n_o = 1'b1;
    // a released wire changes every cycle, so a stale byte never passes
    assign data_o = dev_oe_i ? dev_data_i : (drv ? wd : ~last);
    always @(posedge ref_clk_i) last <= data_o;

    task automatic access(input logic single, input logic rd, input logic [3:0] sel_n,
                          input logic [1:0] chan, input logic [2:0] idx,
                          input logic [7:0] wdat, output logic [7:0] rdat, output logic oe);
        @(posedge ref_clk_i);
        #1;
        idx_o = idx;
        wd = wdat;
        drv = !rd;
        if (single) begin
            csel_o = chan;
            wr_n_o = rd;
            rd_n_o = rd;
        end else begin
            cs_a_n_o = sel_n[0];
            csel_o = sel_n[2:1];
            cs_d_n_o = sel_n[3];
        end
        repeat (2) @(posedge ref_clk_i);
        #1;
        if (single) cs_a_n_o = 1'b0;
        else if (rd) rd_n_o = 1'b0;
        else wr_n_o = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rdat = dev_data_i;
        oe = dev_oe_i;
        cs_a_n_o = 1'b1;
        csel_o = 2'b11;
        cs_d_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        drv = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask
endmodule // host_bus_model

// File: bench/quad_uart_host_bus_decode_tb.sv
`timescale 1ns/100ps
module quad_uart_host_bus_decode_tb;
    import uart_bus_decode_pkg::*;
    logic          ref_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          bus_style = 1'b1;
    logic          reset_pin = 1'b0;
    logic [3:0]    core_int = 4'h0;
    logic          cs_a_n, cs_d_n, rd_n, wr_n, data_oe, irq, irq_oe, core_wr, core_rd, core_reset;
    logic [1:0]    csel;
    logic [2:0]    idx, core_index;
    logic [7:0]    data_pin, data_out, core_wdata;
    logic [3:0]    chan_irq, chan_irq_oe;
    chan_sel_type  core_sel;
    bus_style_type style;
    logic [7:0]    wr_cnt = 8'h00;
    logic [7:0]    rd_cnt = 8'h00;
    int            n_errors = 0;
    int            samples_checked = 0;

    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (core_wr === 1'b1) wr_cnt <= wr_cnt + 8'h01;
    always @(posedge ref_clk) if (core_rd === 1'b1) rd_cnt <= rd_cnt + 8'h01;

    host_bus_model i_host (.ref_clk_i(ref_clk), .dev_data_i(data_out), .dev_oe_i(data_oe),
        .cs_a_n_o(cs_a_n), .csel_o(csel), .cs_d_n_o(cs_d_n), .idx_o(idx), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .data_o(data_pin));
    quad_uart_host_bus_decode i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .bus_style_i(bus_style), .reset_pin_i(reset_pin), .cs_a_n_i(cs_a_n),
        .channel_select_bits_i(csel), .cs_d_n_i(cs_d_n), .register_index_i(idx),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .data_i(data_pin), .data_o(data_out),
        .data_oe_o(data_oe), .chan_irq_o(chan_irq), .chan_irq_oe_o(chan_irq_oe), .irq_o(irq),
        .irq_oe_o(irq_oe), .core_sel_o(core_sel), .core_index_o(core_index),
        .core_wdata_o(core_wdata), .core_wr_o(core_wr), .core_rd_o(core_rd),
        .core_rdata_i({core_sel, 1'b0, core_index}), .core_int_i(core_int),
        .core_reset_o(core_reset), .style_o(style));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        check({6'h00, core_reset, style}, {6'h00, 1'b1, SEPARATE_STROBE});
        rst_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic settle_pins(input logic rp, input logic [3:0] irqs);
        @(posedge ref_clk);
        #1;
        reset_pin = rp;
        core_int = irqs;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    task automatic xfer(input logic single, input logic rd, input logic [3:0] sel_n,
                        input logic [1:0] ch, input logic [2:0] ix, input logic [7:0] wd,
                        input logic hit);
        logic [7:0] w0, r0, rdat;
        logic       oe;
        logic [3:0] onehot;
        w0 = wr_cnt;
        r0 = rd_cnt;
        onehot = 4'h1 << ch;
        i_host.access(single, rd, sel_n, ch, ix, wd, rdat, oe);
        check(wr_cnt - w0, {7'h00, hit & !rd});
        check(rd_cnt - r0, {7'h00, hit & rd});
        check({7'h00, oe}, {7'h00, hit & rd});
        check({7'h00, data_oe}, 8'h00);
        if (hit) begin
            check({4'h0, core_sel}, {4'h0, onehot});
            check({5'h00, core_index}, {5'h00, ix});
            if (rd) check(rdat, {onehot, 1'b0, ix});
            else check(core_wdata, wd);
        end
    endtask

    task automatic t_separate();
        for (int c = 0; c < 4; c++) begin
            xfer(1'b0, 1'b0, ~(4'h1 << c), 2'(c), 3'(c), 8'(8'ha5 ^ c), 1'b1);
            xfer(1'b0, 1'b1, ~(4'h1 << c), 2'(c), 3'(c + 4), 8'h00, 1'b1);
        end
        xfer(1'b0, 1'b0, 4'hf, 2'd0, 3'h1, 8'h33, 1'b0);
        xfer(1'b0, 1'b1, 4'hc, 2'd0, 3'h2, 8'h00, 1'b0);
    endtask

    task automatic t_pins_separate();
        settle_pins(1'b1, 4'h5);
        check({7'h00, core_reset}, 8'h01);
        check({chan_irq, chan_irq_oe}, 8'h5f);
        check({6'h00, irq, irq_oe}, 8'h00);
        settle_pins(1'b0, 4'h0);
        check({7'h00, core_reset}, 8'h00);
    endtask

    task automatic t_single();
        bus_style = 1'b0;
        reset_pin = 1'b1;
        do_reset();
        check({7'h00, style}, {7'h00, SINGLE_STROBE});
        check({7'h00, core_reset}, 8'h00);
        settle_pins(1'b0, 4'h2);
        check({7'h00, core_reset}, 8'h01);
        check({6'h00, irq, irq_oe}, 8'h03);
        check({4'h0, chan_irq_oe}, 8'h00);
        settle_pins(1'b1, 4'h0);
        check({6'h00, irq, irq_oe}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 1'b0, 4'hf, 2'(c), 3'(7 - c), 8'(8'hc0 | c), 1'b1);
            xfer(1'b1, 1'b1, 4'hf, 2'(c), 3'(c), 8'h00, 1'b1);
        end
    endtask

    initial begin
        #50000;
        n_errors++;
        conclude();
    end

    initial begin
        do_reset();
        t_separate();
        t_pins_separate();
        t_single();
        conclude();
    end
endmodule // quad_uart_host_bus_decode_tb
